// ===== logic/pin_state_pkg.sv
// Purpose: Shared types and constants for the standby pin state control.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Power mode codes are supplied by the power controller.

package pin_state_pkg;

    // ----------------------------------------------------------------
    // Power modes requested by the power controller
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_RUN        = 4'h0,
        MODE_SLEEP      = 4'h1,
        MODE_MAIN_TIMER = 4'h2,
        MODE_SUB_TIMER  = 4'h3,
        MODE_LCR_TIMER  = 4'h4,
        MODE_RTC        = 4'h5,
        MODE_STOP       = 4'h6,
        MODE_DEEP_RTC   = 4'h7,
        MODE_DEEP_STOP  = 4'h8,
        MODE_DEEP_RET   = 4'h9
    } power_mode_type;

    // ----------------------------------------------------------------
    // Pin state classes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PS_POR      = 3'h0,
        PS_EXT_RST  = 3'h1,
        PS_INT_RST  = 3'h2,
        PS_RUN      = 3'h3,
        PS_STBY     = 3'h4,
        PS_DEEP     = 3'h5,
        PS_DEEP_RET = 3'h6
    } pin_state_type;

    // ----------------------------------------------------------------
    // Per-pin output source
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DRV_HIZ  = 2'h0,
        DRV_FUNC = 2'h1,
        DRV_PORT = 2'h2,
        DRV_HELD = 2'h3
    } drive_sel_type;

    localparam logic LVL_RESET      = 1'b0;
    localparam logic SYNC_RESET_VAL = 1'b1;
    localparam logic PULL_UP_ON     = 1'b1;
    localparam logic INPUT_ON       = 1'b1;

endpackage

// ===== logic/level_sync3.sv
// Purpose: Three-stage synchroniser for a level from a pin.
// Assumes: Input is asynchronous to clk.
// Notes:   Output moves only when stages two and three agree.

`timescale 1ns/1ps

module level_sync3 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Level
    input  wire logic async_in,
    output logic      sync_out
);

    logic s1_q, s2_q, s3_q, out_q;
    logic s1_d, s2_d, s3_d, out_d;

    always_comb begin
        s1_d  = async_in;
        s2_d  = s1_q;
        s3_d  = s2_q;
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q  <= pin_state_pkg::SYNC_RESET_VAL;
            s2_q  <= pin_state_pkg::SYNC_RESET_VAL;
            s3_q  <= pin_state_pkg::SYNC_RESET_VAL;
            out_q <= pin_state_pkg::SYNC_RESET_VAL;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule

// ===== logic/pin_drive_cell.sv
// Purpose: One pad: output source select, hold latch, input gating.
// Assumes: Controls come from the pin state decoder on the same clock.
// Notes:   All pad outputs are registered, one cycle behind controls.

`timescale 1ns/1ps

module pin_drive_cell (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // Control
    input  wire pin_state_pkg::drive_sel_type drive_sel,
    input  wire logic                         in_gate,
    input  wire logic                         capture,
    // Sources
    input  wire logic                         func_out,
    input  wire logic                         func_oe,
    input  wire logic                         port_out,
    input  wire logic                         port_oe,
    // Pad
    input  wire logic                         pad_in,
    output logic                              pad_out,
    output logic                              pad_oe,
    output logic                              core_in
);

    logic held_out_q, held_oe_q, out_q, oe_q, in_q;
    logic held_out_d, held_oe_d, out_d, oe_d, in_d;

    always_comb begin
        held_out_d = capture ? port_out : held_out_q;
        held_oe_d  = capture ? port_oe  : held_oe_q;
        unique case (drive_sel)
            pin_state_pkg::DRV_HIZ: begin
                out_d = 1'b0;
                oe_d  = 1'b0;
            end
            pin_state_pkg::DRV_FUNC: begin
                out_d = func_out;
                oe_d  = func_oe;
            end
            pin_state_pkg::DRV_PORT: begin
                out_d = port_out;
                oe_d  = port_oe;
            end
            pin_state_pkg::DRV_HELD: begin
                out_d = held_out_q;
                oe_d  = held_oe_q;
            end
        endcase
        // Gated input reads low, not the pad
        in_d = in_gate ? 1'b0 : pad_in;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            held_out_q <= 1'b0;
            held_oe_q  <= 1'b0;
            out_q      <= 1'b0;
            oe_q       <= 1'b0;
            in_q       <= 1'b0;
        end else begin
            held_out_q <= held_out_d;
            held_oe_q  <= held_oe_d;
            out_q      <= out_d;
            oe_q       <= oe_d;
            in_q       <= in_d;
        end
    end

    assign pad_out = out_q;
    assign pad_oe  = oe_q;
    assign core_in = in_q;

endmodule

// ===== logic/standby_pin_state_control.sv
// Purpose: Pin drive and input gating for every reset and power state.
// Assumes: Power controller gives mode codes; pads resolve oe/out.
// Notes:   Reset classes outrank the requested power mode.
//
// Function
// - Software-writable standby pin level bit selects standby pin behaviour.
// - An unusable input reads constant low inside the device.
// - A high-impedance pin has its output driver turned off.
// - Held pins: peripherals keep driving, port pins keep last value.
// - Deep standby switches pins to port function.
// - Deep standby: level 0 port-driven input low; level 1 Hi-Z input low.
// - Timer/RTC/stop: level 0 holds state; level 1 Hi-Z input low.
// - External reset pin keeps pull-up and input on in every state.
// - Main clock input pin keeps input enabled in every state.
// - Oscillator output holds while running, Hi-Z input low once stopped.
// - During any reset, port pins ignore function configuration.
// - External clock pin: deep level 0 holds, level 1 Hi-Z input low.
// - Whole low time of external reset pin is the external reset state; code enters it only after level_sync3 and drops lows under two clocks.
// - Main oscillator stops in sub/CR timer, RTC, stop, deep RTC and deep stop modes.

`timescale 1ns/1ps

module standby_pin_state_control #(
    parameter int N_PINS = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Power controller
    input  wire logic              por_active,
    input  wire logic              int_reset_active,
    input  wire logic [3:0]        power_mode,
    // Standby mode control write
    input  wire logic              ctrl_wr_en,
    input  wire logic              ctrl_wr_lvl,
    output logic                   standby_pin_level_sel,
    // External reset pad
    input  wire logic              external_reset_input_n,
    output logic                   ext_reset_pullup_en,
    output logic                   ext_reset_input_en,
    output logic                   ext_reset_core_n,
    // Mode pad
    output logic                   mode_pin_input_en,
    // General pins
    input  wire logic [N_PINS-1:0] func_sel,
    input  wire logic [N_PINS-1:0] periph_out,
    input  wire logic [N_PINS-1:0] periph_oe,
    input  wire logic [N_PINS-1:0] port_out,
    input  wire logic [N_PINS-1:0] port_oe,
    input  wire logic [N_PINS-1:0] pad_in,
    output logic      [N_PINS-1:0] pad_out,
    output logic      [N_PINS-1:0] pad_oe,
    output logic      [N_PINS-1:0] core_in,
    // Main oscillator input pad
    input  wire logic              x0_osc_sel,
    input  wire logic              x0_pad_in,
    output logic                   x0_core_in,
    // Main oscillator output pad
    input  wire logic              x1_ext_clk_mode,
    input  wire logic              osc_drive,
    input  wire logic              x1_port_out,
    input  wire logic              x1_port_oe,
    input  wire logic              x1_pad_in,
    output logic                   x1_pad_out,
    output logic                   x1_pad_oe,
    output logic                   x1_core_in,
    // Status
    output pin_state_pkg::pin_state_type pin_state,
    output logic                   main_osc_stopped
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic pin_state_pkg::pin_state_type decode_state(
        input logic                          por,
        input logic                          ext_rst,
        input logic                          int_rst,
        input pin_state_pkg::power_mode_type m
    );
        if (por) begin
            return pin_state_pkg::PS_POR;
        end
        if (ext_rst) begin
            return pin_state_pkg::PS_EXT_RST;
        end
        if (int_rst) begin
            return pin_state_pkg::PS_INT_RST;
        end
        unique case (m)
            pin_state_pkg::MODE_RUN,
            pin_state_pkg::MODE_SLEEP:      return pin_state_pkg::PS_RUN;
            pin_state_pkg::MODE_MAIN_TIMER,
            pin_state_pkg::MODE_SUB_TIMER,
            pin_state_pkg::MODE_LCR_TIMER,
            pin_state_pkg::MODE_RTC,
            pin_state_pkg::MODE_STOP:       return pin_state_pkg::PS_STBY;
            pin_state_pkg::MODE_DEEP_RTC,
            pin_state_pkg::MODE_DEEP_STOP:  return pin_state_pkg::PS_DEEP;
            pin_state_pkg::MODE_DEEP_RET:   return pin_state_pkg::PS_DEEP_RET;
            // Unknown codes treated as run: safest for live pins
            default:                        return pin_state_pkg::PS_RUN;
        endcase
    endfunction

    function automatic logic osc_is_stopped(
        input pin_state_pkg::power_mode_type m
    );
        return (m == pin_state_pkg::MODE_SUB_TIMER) ||
               (m == pin_state_pkg::MODE_LCR_TIMER) ||
               (m == pin_state_pkg::MODE_RTC)       ||
               (m == pin_state_pkg::MODE_STOP)      ||
               (m == pin_state_pkg::MODE_DEEP_RTC)  ||
               (m == pin_state_pkg::MODE_DEEP_STOP);
    endfunction

    function automatic logic in_reset(
        input pin_state_pkg::pin_state_type s
    );
        return (s == pin_state_pkg::PS_POR)     ||
               (s == pin_state_pkg::PS_EXT_RST) ||
               (s == pin_state_pkg::PS_INT_RST);
    endfunction

    function automatic pin_state_pkg::drive_sel_type port_drive(
        input pin_state_pkg::pin_state_type s,
        input logic                         lvl,
        input logic                         func
    );
        if (in_reset(s)) begin
            return pin_state_pkg::DRV_HIZ;
        end
        unique case (s)
            pin_state_pkg::PS_RUN:
                return func ? pin_state_pkg::DRV_FUNC
                            : pin_state_pkg::DRV_PORT;
            pin_state_pkg::PS_STBY: begin
                if (lvl) begin
                    return pin_state_pkg::DRV_HIZ;
                end
                return func ? pin_state_pkg::DRV_FUNC
                            : pin_state_pkg::DRV_HELD;
            end
            pin_state_pkg::PS_DEEP:
                return lvl ? pin_state_pkg::DRV_HIZ
                           : pin_state_pkg::DRV_PORT;
            default:
                return pin_state_pkg::DRV_PORT;
        endcase
    endfunction

    function automatic logic port_gate(
        input pin_state_pkg::pin_state_type s,
        input logic                         lvl
    );
        if (in_reset(s) || s == pin_state_pkg::PS_DEEP) begin
            return 1'b1;
        end
        return (s == pin_state_pkg::PS_STBY) && lvl;
    endfunction

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    logic                           ext_rst_n_sync;
    logic                           lvl_q, lvl_d;
    pin_state_pkg::power_mode_type  mode_q, mode_d;
    pin_state_pkg::pin_state_type   state_q, state_d;
    logic                           capture;

    level_sync3 u_ext_rst_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (external_reset_input_n),
        .sync_out (ext_rst_n_sync)
    );

    always_comb begin
        lvl_d   = ctrl_wr_en ? ctrl_wr_lvl : lvl_q;
        mode_d  = pin_state_pkg::power_mode_type'(power_mode);
        state_d = decode_state(por_active, !ext_rst_n_sync,
                               int_reset_active, mode_d);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lvl_q   <= pin_state_pkg::LVL_RESET;
            mode_q  <= pin_state_pkg::MODE_RUN;
            state_q <= pin_state_pkg::PS_POR;
        end else begin
            lvl_q   <= lvl_d;
            mode_q  <= mode_d;
            state_q <= state_d;
        end
    end

    // Hold latches track run values, freeze on leaving run
    assign capture = (state_q == pin_state_pkg::PS_RUN);

    // ----------------------------------------------------------------
    // General pins
    // ----------------------------------------------------------------
    for (genvar i = 0; i < N_PINS; i++) begin : g_pin
        pin_drive_cell u_cell (
            .clk       (clk),
            .resetn    (resetn),
            .drive_sel (port_drive(state_q, lvl_q, func_sel[i])),
            .in_gate   (port_gate(state_q, lvl_q)),
            .capture   (capture),
            .func_out  (periph_out[i]),
            .func_oe   (periph_oe[i]),
            .port_out  (port_out[i]),
            .port_oe   (port_oe[i]),
            .pad_in    (pad_in[i]),
            .pad_out   (pad_out[i]),
            .pad_oe    (pad_oe[i]),
            .core_in   (core_in[i])
        );
    end

    // ----------------------------------------------------------------
    // Oscillator output pin
    // ----------------------------------------------------------------
    pin_state_pkg::drive_sel_type x1_sel;
    logic                         x1_gate;

    always_comb begin
        if (x1_ext_clk_mode) begin
            if (state_q == pin_state_pkg::PS_DEEP) begin
                x1_sel  = lvl_q ? pin_state_pkg::DRV_HIZ
                                : pin_state_pkg::DRV_HELD;
                x1_gate = lvl_q;
            end else begin
                x1_sel  = port_drive(state_q, lvl_q, 1'b0);
                x1_gate = port_gate(state_q, lvl_q);
            end
        end else if (in_reset(state_q) || osc_is_stopped(mode_q)) begin
            x1_sel  = pin_state_pkg::DRV_HIZ;
            x1_gate = 1'b1;
        end else begin
            // Crystal drive keeps going while oscillating
            x1_sel  = pin_state_pkg::DRV_FUNC;
            x1_gate = 1'b0;
        end
    end

    pin_drive_cell u_x1_cell (
        .clk       (clk),
        .resetn    (resetn),
        .drive_sel (x1_sel),
        .in_gate   (x1_gate),
        .capture   (capture),
        .func_out  (osc_drive),
        .func_oe   (1'b1),
        .port_out  (x1_port_out),
        .port_oe   (x1_port_oe),
        .pad_in    (x1_pad_in),
        .pad_out   (x1_pad_out),
        .pad_oe    (x1_pad_oe),
        .core_in   (x1_core_in)
    );

    // ----------------------------------------------------------------
    // Always-on inputs
    // ----------------------------------------------------------------
    logic x0_in_q, x0_in_d;

    always_comb begin
        x0_in_d = x0_osc_sel ? x0_pad_in : 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            x0_in_q <= 1'b0;
        end else begin
            x0_in_q <= x0_in_d;
        end
    end

    assign x0_core_in            = x0_in_q;
    assign ext_reset_pullup_en   = pin_state_pkg::PULL_UP_ON;
    assign ext_reset_input_en    = pin_state_pkg::INPUT_ON;
    assign ext_reset_core_n      = ext_rst_n_sync;
    assign mode_pin_input_en     = pin_state_pkg::INPUT_ON;
    assign standby_pin_level_sel = lvl_q;
    assign pin_state             = state_q;
    assign main_osc_stopped      = osc_is_stopped(mode_q);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_level_write: assert property (
        ctrl_wr_en |=> standby_pin_level_sel == $past(ctrl_wr_lvl))
        else $error("level bit did not take written value");

    a_gate_low: assert property (
        (state_q == pin_state_pkg::PS_STBY && lvl_q) |=> core_in == '0)
        else $error("gated input not low in standby");

    a_reset_hiz: assert property (
        in_reset(state_q) |=> (pad_oe == '0) && (core_in == '0))
        else $error("pin driven during reset");

    a_deep_port: assert property (
        (state_q == pin_state_pkg::PS_DEEP && !lvl_q)
        |=> pad_oe == $past(port_oe) && core_in == '0)
        else $error("deep standby pins not port-driven");

    a_deep_hiz: assert property (
        (state_q == pin_state_pkg::PS_DEEP && lvl_q) |=> pad_oe == '0)
        else $error("deep standby pins not high impedance");

    a_pullup_on: assert property (
        ext_reset_pullup_en && ext_reset_input_en)
        else $error("reset pin pull-up or input off");

    a_x0_input: assert property (
        x0_osc_sel |=> x0_core_in == $past(x0_pad_in))
        else $error("clock input pin not passed through");

    a_osc_hiz: assert property (
        (!x1_ext_clk_mode && main_osc_stopped)
        |=> !x1_pad_oe && !x1_core_in)
        else $error("oscillator pin driven while stopped");

    a_x1_hold: assert property (
        (x1_ext_clk_mode && !lvl_q &&
         state_q == pin_state_pkg::PS_DEEP) [*2]
        |=> $stable(x1_pad_out) && $stable(x1_pad_oe))
        else $error("clock pin did not hold in deep standby");

    a_ext_reset: assert property (
        (!external_reset_input_n && !por_active) [*4]
        |-> ##[1:2] state_q == pin_state_pkg::PS_EXT_RST)
        else $error("external reset state not entered");

    a_state_steady: assert property (
        ($stable(power_mode) && $stable(por_active) && $stable(resetn) &&
         $stable(int_reset_active) && $stable(ext_rst_n_sync)) [*2]
        |-> $stable(state_q))
        else $error("pin state changed without a mode change");

    c_deep: cover property (state_q == pin_state_pkg::PS_DEEP);
    c_stby_hiz: cover property (state_q == pin_state_pkg::PS_STBY && lvl_q);
    c_ext_rst: cover property (state_q == pin_state_pkg::PS_EXT_RST);
    c_deep_ret: cover property (
        state_q == pin_state_pkg::PS_DEEP ##1
        state_q == pin_state_pkg::PS_DEEP_RET);

endmodule

// ===== verification/board_pins.sv
// Purpose: Board circuitry seen by the general and oscillator pads.
// Assumes: The board biases every pad to its own level when released.
// Notes:   A released pad shows the board level, never the device's last.

`timescale 1ns/1ps

module board_pins #(
    parameter int W = 9
) (
    // Device drive
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    // Board bias, reshuffled by the bench every step
    input  wire logic [W-1:0] board_lvl,
    // Pad level back to the device
    output logic      [W-1:0] pad_in
);
    // -----------------------------------------------------------------
    // Pad resolution
    // -----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : board_lvl[i];
        end
    end
endmodule

// ===== verification/tb_standby_pin_state_control.sv
// Purpose: Self-checking bench for the standby pin state control.
// Assumes: Pad outputs settle within six edges of any input change.
// Notes:   Every power mode and reset class is run with both level bits.

`timescale 1ns/1ps

module tb_standby_pin_state_control;
    localparam int N = 8;
    logic                 clk, resetn, por_active, int_reset_active;
    logic [3:0]           power_mode;
    logic                 ctrl_wr_en, ctrl_wr_lvl, lvl_sel, ext_n;
    logic                 pu_en, in_en, core_n, mode_en, osc_stop;
    logic [N-1:0]         func_sel, periph_out, periph_oe, port_out;
    logic [N-1:0]         port_oe, pad_out, pad_oe, core_in;
    logic                 x0_osc_sel, x0_pad_in, x0_core_in, x1_ext;
    logic                 osc_drive, x1_port_out, x1_port_oe;
    logic                 x1_pad_out, x1_pad_oe, x1_core_in;
    logic [N:0]           board_lvl;
    wire logic [N:0]      pads_in;
    logic [15:0]          seed;
    int                   num_errors, comparisons, cycles;
    pin_state_pkg::pin_state_type pin_state;

    standby_pin_state_control #(.N_PINS(N)) dut (
        .clk(clk), .resetn(resetn), .por_active(por_active),
        .int_reset_active(int_reset_active), .power_mode(power_mode),
        .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_lvl(ctrl_wr_lvl),
        .standby_pin_level_sel(lvl_sel), .external_reset_input_n(ext_n),
        .ext_reset_pullup_en(pu_en), .ext_reset_input_en(in_en),
        .ext_reset_core_n(core_n), .mode_pin_input_en(mode_en),
        .func_sel(func_sel), .periph_out(periph_out),
        .periph_oe(periph_oe), .port_out(port_out), .port_oe(port_oe),
        .pad_in(pads_in[N-1:0]), .pad_out(pad_out), .pad_oe(pad_oe),
        .core_in(core_in), .x0_osc_sel(x0_osc_sel),
        .x0_pad_in(x0_pad_in), .x0_core_in(x0_core_in),
        .x1_ext_clk_mode(x1_ext), .osc_drive(osc_drive),
        .x1_port_out(x1_port_out), .x1_port_oe(x1_port_oe),
        .x1_pad_in(pads_in[N]), .x1_pad_out(x1_pad_out),
        .x1_pad_oe(x1_pad_oe), .x1_core_in(x1_core_in),
        .pin_state(pin_state), .main_osc_stopped(osc_stop));

    board_pins #(.W(N+1)) board (
        .pad_out({x1_pad_out, pad_out}), .pad_oe({x1_pad_oe, pad_oe}),
        .board_lvl(board_lvl), .pad_in(pads_in));

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Function select is only reshuffled in run, so held pins stay valid
    task automatic shuffle(input bit with_func);
        logic [15:0] r;
        r = rnd();
        periph_out = r[7:0];
        periph_oe = r[15:8];
        r = rnd();
        port_out = r[7:0];
        port_oe = r[15:8];
        r = rnd();
        board_lvl = r[8:0];
        osc_drive = r[9];
        x1_port_out = r[10];
        x1_port_oe = r[11];
        x0_pad_in = r[12];
        if (with_func) begin
            r = rnd();
            func_sel = r[7:0];
            x0_osc_sel = r[8];
        end
    endtask

    // k 0..10 power mode code, 11 power-on, 12 pad reset, 13 internal
    task automatic run_case(input int k, input logic lvl);
        logic [N:0] h_out, h_oe, e_oe, e_out, live, f, p_oe, p_out;
        int st;
        bit stop;
        @(negedge clk);
        ctrl_wr_en = 1'b1;
        ctrl_wr_lvl = lvl;
        @(negedge clk);
        ctrl_wr_en = 1'b0;
        check("level_sel", 16'(lvl_sel), 16'(lvl));
        power_mode = 4'h0;
        x1_ext = lvl ^ k[0];
        shuffle(1'b1);
        repeat (4) @(negedge clk);
        h_out = {x1_port_out, port_out};
        h_oe = {x1_port_oe, port_oe};
        if (k < 11) power_mode = 4'(k);
        por_active = (k == 11);
        ext_n = (k != 12);
        int_reset_active = (k == 13);
        repeat (2) @(negedge clk);
        shuffle(1'b0);
        repeat (8) @(negedge clk);
        st = (k == 11) ? 0 : (k == 12) ? 1 : (k == 13) ? 2 :
             (k < 2 || k > 9) ? 3 : (k < 7) ? 4 : (k < 9) ? 5 : 6;
        stop = (k >= 3 && k <= 8);
        f = {1'b0, func_sel};
        p_oe = {x1_port_oe, port_oe};
        p_out = {x1_port_out, port_out};
        e_oe = '0;
        e_out = '0;
        live = '0;
        case (st)
            3: begin
                e_oe = (f & {1'b0, periph_oe}) | (~f & p_oe);
                e_out = (f & {1'b0, periph_out}) | (~f & p_out);
                live = '1;
            end
            6: begin
                e_oe = p_oe;
                e_out = p_out;
                live = '1;
            end
            4: if (!lvl) begin
                e_oe = (f & {1'b0, periph_oe}) | (~f & h_oe);
                e_out = (f & {1'b0, periph_out}) | (~f & h_out);
                live = '1;
            end
            5: if (!lvl) begin
                e_oe = p_oe;
                e_out = p_out;
                if (x1_ext) begin
                    e_oe[N] = h_oe[N];
                    e_out[N] = h_out[N];
                    live[N] = 1'b1;
                end
            end
            default: ;
        endcase
        if (!x1_ext) begin
            e_oe[N] = !(st < 3 || stop);
            e_out[N] = osc_drive;
            live[N] = 1'b0;
        end
        check("pin_state", 16'(pin_state), 16'(st));
        check("osc_stopped", 16'(osc_stop), 16'(stop));
        check("pad_oe", 16'({x1_pad_oe, pad_oe}), 16'(e_oe));
        check("pad_out", 16'({x1_pad_out, pad_out} & e_oe),
              16'(e_out & e_oe));
        if (x1_ext || !e_oe[N]) begin
            check("core_in", 16'({x1_core_in, core_in}),
                  16'(live & ((e_oe & e_out) | (~e_oe & board_lvl))));
        end
        else begin
            check("core_in", 16'(core_in),
                  16'(live[N-1:0] & ((e_oe[N-1:0] & e_out[N-1:0]) |
                      (~e_oe[N-1:0] & board_lvl[N-1:0]))));
            check("x1_core", 16'(x1_core_in), 16'(osc_drive));
        end
        check("x0_core", 16'(x0_core_in), 16'(x0_osc_sel & x0_pad_in));
        check("rst_pin_en", 16'({pu_en, in_en, mode_en}), 16'h0007);
        check("rst_core_n", 16'(core_n), 16'(k != 12));
        por_active = 1'b0;
        int_reset_active = 1'b0;
        ext_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    // -----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        {resetn, por_active, int_reset_active, ctrl_wr_en} = '0;
        {ctrl_wr_lvl, x1_ext, power_mode, func_sel} = '0;
        ext_n = 1'b1;
        seed = 16'h0063;
        shuffle(1'b1);
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        for (int k = 0; k < 14; k++) begin
            run_case(k, 1'b0);
            run_case(k, 1'b1);
        end
        summarize();
    end
endmodule
